// >>> verilog/dcp_top.v
// two-channel 12-bit pulse-width modulator with its register port
// assumes a same-clock master: one-cycle strobes, read data next cycle
`timescale 1ns/1ps
`include "dcp_consts.vh"

module dcp_top
#(
   parameter CHANNELS = 2
)
(
   input wire clk_sys_in,
   input wire rst_in,
   input wire [15:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [15:0] rdata_out,
   output reg modulated_output_pin0_out,
   output reg modulated_output_pin1_out
);

   // ****************************************************************
   // register file
   // ****************************************************************
   reg [7:0] pwm_control_reg;
   reg [7:0] pwm_control_next;
   reg [7:0] pwm_clock_divider_reg;
   // no reset: content is undefined until software loads it
   reg [15:0] pulse_width_ch0_reg;
   reg [15:0] pulse_width_ch1_reg;
   reg [1:0] loaded_reg;
   reg [15:0] rdata_next;

   wire [1:0] running_w;
   wire [1:0] pin_w;
   wire [7:0] frame_pos_w;
   wire [31:0] width_buf_w;

   wire wr_ctrl;
   wire wr_set;
   wire wr_clr;
   wire wr_div;
   wire wr_w0;
   wire wr_w1;

   // one exact match per register; near addresses must not alias
   function strobe_hit;
      input strobe;
      input [15:0] addr;
      input [15:0] target;
      begin
         strobe_hit = strobe && (addr == target);
      end
   endfunction

   assign wr_ctrl = strobe_hit(wr_in, addr_in, `DCP_ADDR_CONTROL);
   assign wr_set = strobe_hit(wr_in, addr_in, `DCP_ADDR_CTRL_SET);
   assign wr_clr = strobe_hit(wr_in, addr_in, `DCP_ADDR_CTRL_CLR);
   assign wr_div = strobe_hit(wr_in, addr_in, `DCP_ADDR_DIVIDER);
   assign wr_w0 = strobe_hit(wr_in, addr_in, `DCP_ADDR_WIDTH0);
   assign wr_w1 = strobe_hit(wr_in, addr_in, `DCP_ADDR_WIDTH1);

   // byte write, or bit set / bit clear through a mask
   always @*
   begin
      pwm_control_next = pwm_control_reg;
      if (wr_ctrl)
      begin
         pwm_control_next = wdata_in[7:0];
      end
      else if (wr_set)
      begin
         pwm_control_next = pwm_control_reg | wdata_in[7:0];
      end
      else if (wr_clr)
      begin
         pwm_control_next = pwm_control_reg & ~wdata_in[7:0];
      end
   end

   always @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         pwm_control_reg <= `DCP_CONTROL_RESET;
         pwm_clock_divider_reg <= `DCP_DIVIDER_RESET;
         loaded_reg <= 2'h0;
      end
      else
      begin
         pwm_control_reg <= pwm_control_next & `DCP_CONTROL_RD_MASK;
         if (wr_div)
         begin
            pwm_clock_divider_reg <= wdata_in[7:0];
         end
         if (wr_w0)
         begin
            loaded_reg[0] <= 1'b1;
         end
         if (wr_w1)
         begin
            loaded_reg[1] <= 1'b1;
         end
      end
   end

   // width buffers: whole-word writes only, held until the boundary
   always @(posedge clk_sys_in)
   begin
      if (wr_w0)
      begin
         pulse_width_ch0_reg <= wdata_in;
      end
      if (wr_w1)
      begin
         pulse_width_ch1_reg <= wdata_in;
      end
   end

   assign width_buf_w = {pulse_width_ch1_reg, pulse_width_ch0_reg};

   // ****************************************************************
   // read path
   // ****************************************************************
   always @*
   begin
      case (addr_in)
         `DCP_ADDR_CONTROL: rdata_next = {8'h00, pwm_control_reg & `DCP_CONTROL_RD_MASK};
         `DCP_ADDR_DIVIDER: rdata_next = {8'h00, pwm_clock_divider_reg};
         `DCP_ADDR_WIDTH0: rdata_next = pulse_width_ch0_reg;
         `DCP_ADDR_WIDTH1: rdata_next = pulse_width_ch1_reg;
         `DCP_ADDR_STATUS: rdata_next = {4'h0, loaded_reg, running_w, frame_pos_w};
         default: rdata_next = 16'h0000;
      endcase
   end

   always @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         rdata_out <= 16'h0000;
      end
      else if (rd_in)
      begin
         rdata_out <= rdata_next;
      end
      else
      begin
         // read data stands for one cycle only
         rdata_out <= 16'h0000;
      end
   end

   // ****************************************************************
   // modulator channels
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < CHANNELS; i = i + 1)
      begin : ch
         wire alv;
         wire en;
         wire syn;
         wire [2:0] div_sel;
         wire tick;
         wire start_cyc;
         wire frame_start;
         wire adopt;
         wire [15:0] width_use;
         wire [7:0] coarse;
         wire extra;
         reg run_reg;
         reg en_d_reg;
         reg [7:0] cyc_pos_reg;
         reg [3:0] frame_pos_reg;
         reg [7:0] down_reg;
         reg ext_pend_reg;
         reg act_reg;
         reg pin_reg;
         reg [15:0] width_act_reg;

         assign alv = pwm_control_reg[2 * i + `DCP_CTRL_ALV_BIT];
         assign en = pwm_control_reg[2 * i + `DCP_CTRL_EN_BIT];
         assign syn = pwm_control_reg[`DCP_CTRL_SYN_TOP - i];
         assign div_sel = pwm_clock_divider_reg[`DCP_DIV_FIELD_STEP * i +: 3];

         // prescaler restarts while idle so the first cycle is whole
         dcp_prescaler dcp_prescaler_i
         (
            .clk_sys_in(clk_sys_in),
            .rst_in(rst_in),
            .restart_in(~run_reg),
            .sel_in(div_sel),
            .tick_out(tick)
         );

         assign start_cyc = tick && (cyc_pos_reg == 8'h00);
         assign frame_start = start_cyc && (frame_pos_reg == 4'h0);
         // adoption only at the boundary the update bit selects
         assign adopt = syn ? start_cyc : frame_start;
         assign width_use = adopt ? width_buf_w[16 * i +: 16] : width_act_reg;
         // low four bits take no part in the pulse
         assign coarse = width_use[15:8];

         dcp_extra_sel dcp_extra_sel_i
         (
            .fine_in(width_use[7:4]),
            .frame_pos_in(frame_pos_reg),
            .extra_out(extra)
         );

         // run control: starts on a frame boundary, stops at once
         always @(posedge clk_sys_in)
         begin
            if (rst_in)
            begin
               run_reg <= 1'b0;
               en_d_reg <= 1'b0;
            end
            else
            begin
               en_d_reg <= en;
               if (!en)
               begin
                  run_reg <= 1'b0;
               end
               else if (loaded_reg[i])
               begin
                  // counters sit at zero, so output opens a fresh frame
                  run_reg <= 1'b1;
               end
            end
         end

         // basic cycle and frame position counters
         always @(posedge clk_sys_in)
         begin
            if (rst_in || !run_reg)
            begin
               cyc_pos_reg <= 8'h00;
               frame_pos_reg <= 4'h0;
            end
            else if (tick)
            begin
               cyc_pos_reg <= cyc_pos_reg + 8'h01;
               if (cyc_pos_reg == `DCP_CYCLE_LAST)
               begin
                  frame_pos_reg <= frame_pos_reg + 4'h1;
               end
            end
         end

         // pulse timing: down counter plus one optional extra clock
         always @(posedge clk_sys_in)
         begin
            if (rst_in || !run_reg)
            begin
               down_reg <= 8'h00;
               ext_pend_reg <= 1'b0;
               act_reg <= 1'b0;
            end
            else if (start_cyc)
            begin
               act_reg <= (coarse != 8'h00) || extra;
               down_reg <= coarse - {7'h00, (coarse != 8'h00)};
               ext_pend_reg <= (coarse != 8'h00) && extra;
            end
            else if (tick)
            begin
               if (down_reg != 8'h00)
               begin
                  act_reg <= 1'b1;
                  down_reg <= down_reg - 8'h01;
               end
               else if (ext_pend_reg)
               begin
                  act_reg <= 1'b1;
                  ext_pend_reg <= 1'b0;
               end
               else
               begin
                  act_reg <= 1'b0;
               end
            end
         end

         always @(posedge clk_sys_in)
         begin
            if (adopt && run_reg)
            begin
               width_act_reg <= width_buf_w[16 * i +: 16];
            end
         end

         // output control: polarity applied live, pin parked at inactive level then held when disabled
         always @(posedge clk_sys_in)
         begin
            if (rst_in)
            begin
               pin_reg <= 1'b0;
            end
            else if (en && run_reg)
            begin
               pin_reg <= alv ? act_reg : ~act_reg;
            end
            else if (en)
            begin
               // enabled but waiting for width: idle at inactive level
               pin_reg <= ~alv;
            end
            else if (en_d_reg)
            begin
               pin_reg <= ~alv;
            end
            else
            begin
               // disabled: alv writes do not reach the pin
               pin_reg <= pin_reg;
            end
         end

         assign running_w[i] = run_reg;
         assign pin_w[i] = pin_reg;
         assign frame_pos_w[4 * i +: 4] = frame_pos_reg;
      end
   endgenerate

   // ****************************************************************
   // pins
   // ****************************************************************
   // one extra flop keeps the top outputs straight from registers
   always @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         modulated_output_pin0_out <= 1'b0;
         modulated_output_pin1_out <= 1'b0;
      end
      else
      begin
         modulated_output_pin0_out <= pin_w[0];
         modulated_output_pin1_out <= pin_w[1];
      end
   end

endmodule // dcp_top

// >>> verilog/dcp_consts.vh
// constants of the dual channel 12-bit pulse-width modulator
// assumes one system clock and a plain address/strobe register port
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define DCP_ADDR_CONTROL 16'hff70
`define DCP_ADDR_DIVIDER 16'hff71
`define DCP_ADDR_WIDTH0 16'hff72
`define DCP_ADDR_WIDTH1 16'hff74
`define DCP_ADDR_STATUS 16'hff76
`define DCP_ADDR_CTRL_SET 16'hff78
`define DCP_ADDR_CTRL_CLR 16'hff79

// ****************************************************************
// reset values and field layout
// ****************************************************************
`define DCP_CONTROL_RESET 8'h05
`define DCP_DIVIDER_RESET 8'h00
`define DCP_CONTROL_RD_MASK 8'hcf
`define DCP_CTRL_ALV_BIT 0
`define DCP_CTRL_EN_BIT 1
`define DCP_CTRL_SYN_TOP 7
`define DCP_DIV_FIELD_STEP 4

// ****************************************************************
// divider codes and timing
// ****************************************************************
`define DCP_DIV_CODE_1 3'h0
`define DCP_DIV_CODE_2 3'h2
`define DCP_DIV_CODE_3 3'h3
`define DCP_DIV_CODE_4 3'h4
`define DCP_CYCLE_LAST 8'hff
`define DCP_FRAME_LAST 4'hf

`endif

// >>> verilog/dcp_prescaler.v
// operating-clock enable for one modulator channel
// assumes the divider code is steady while the channel runs
`timescale 1ns/1ps
`include "dcp_consts.vh"

module dcp_prescaler
(
   input wire clk_sys_in,
   input wire rst_in,
   input wire restart_in,
   input wire [2:0] sel_in,
   output reg tick_out
);

   reg [1:0] cnt_reg;
   wire [1:0] last;

   // ****************************************************************
   // code to terminal count
   // ****************************************************************
   function [1:0] div_last;
      input [2:0] code;
      begin
         case (code)
            `DCP_DIV_CODE_2: div_last = 2'h1;
            `DCP_DIV_CODE_3: div_last = 2'h2;
            `DCP_DIV_CODE_4: div_last = 2'h3;
            // prohibited codes fall back to undivided
            default: div_last = 2'h0;
         endcase
      end
   endfunction

   assign last = div_last(sel_in);

   always @(posedge clk_sys_in)
   begin
      if (rst_in || restart_in)
      begin
         cnt_reg <= 2'h0;
         tick_out <= 1'b0;
      end
      else if (cnt_reg >= last)
      begin
         cnt_reg <= 2'h0;
         tick_out <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 2'h1;
         tick_out <= 1'b0;
      end
   end

endmodule // dcp_prescaler

// >>> verilog/dcp_extra_sel.v
// decides whether a basic cycle of the frame gets one extra clock
// assumes frame position counts 0 to 15 within each frame
`timescale 1ns/1ps

module dcp_extra_sel
(
   input wire [3:0] fine_in,
   input wire [3:0] frame_pos_in,
   output wire extra_out
);

   wire [3:0] spread;

   // bit-reversed position spreads the extras evenly over the frame
   assign spread = {frame_pos_in[0], frame_pos_in[1], frame_pos_in[2], frame_pos_in[3]};
   // fine value f lengthens f+1 cycles of 16, the +1 of the duty
   assign extra_out = (spread <= fine_in);

endmodule // dcp_extra_sel

// >>> verif/dcp_top_assertions.sv
// checker for the modulator top: register reads and parked pins
// assumes it is bound to dcp_top; one clock, synchronous reset
`timescale 1ns/1ps

module dcp_top_checker
#(
   parameter CHANNELS = 2
)
(
   input wire clk_sys_in,
   input wire rst_in,
   input wire [15:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [15:0] rdata_out,
   input wire modulated_output_pin0_out,
   input wire modulated_output_pin1_out
);
   // ********
   // shadow of control, width loads and idle time
   // ********
   reg [7:0] ctl_reg;
   reg [7:0] ctl_next;
   reg [3:0] off0_reg;
   reg [3:0] off1_reg;
   reg alv0_reg;
   reg alv1_reg;
   reg wl0_reg;
   reg wl1_reg;

   always @*
   begin
      ctl_next = ctl_reg;
      if (wr_in && addr_in == 16'hff70)
         ctl_next = wdata_in[7:0] & 8'hcf;
      if (wr_in && addr_in == 16'hff78)
         ctl_next = (ctl_reg | wdata_in[7:0]) & 8'hcf;
      if (wr_in && addr_in == 16'hff79)
         ctl_next = ctl_reg & ~wdata_in[7:0];
   end

   // idle counters saturate at 15, well past the output pipeline
   always @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         ctl_reg <= 8'h05;
         off0_reg <= 4'h0;
         off1_reg <= 4'h0;
         alv0_reg <= 1'b1;
         alv1_reg <= 1'b1;
         wl0_reg <= 1'b0;
         wl1_reg <= 1'b0;
      end
      else
      begin
         ctl_reg <= ctl_next;
         off0_reg <= ctl_next[1] ? 4'h0 : off0_reg + {3'h0, off0_reg != 4'hf};
         off1_reg <= ctl_next[3] ? 4'h0 : off1_reg + {3'h0, off1_reg != 4'hf};
         if (ctl_reg[1] && !ctl_next[1])
            alv0_reg <= ctl_next[0];
         if (ctl_reg[3] && !ctl_next[3])
            alv1_reg <= ctl_next[2];
         if (wr_in && addr_in == 16'hff72)
            wl0_reg <= 1'b1;
         if (wr_in && addr_in == 16'hff74)
            wl1_reg <= 1'b1;
      end
   end

   // ********
   // assertions
   // ********
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   sequence s_ctl_read;
      rd_in && addr_in == 16'hff70;
   endsequence
   sequence s_quiet0;
      (!wl0_reg && ctl_reg[1] && $stable(ctl_reg[0])) [*4];
   endsequence
   sequence s_quiet1;
      (!wl1_reg && ctl_reg[3] && $stable(ctl_reg[2])) [*4];
   endsequence

   a_rdata_idle: assert property (!rd_in |=> rdata_out == 16'h0000)
      else $error("read data not zero outside a read");
   a_ctrl_readback: assert property (s_ctl_read |=> rdata_out == {8'h00, $past(ctl_reg)})
      else $error("control read mismatch");
   a_unmapped_zero: assert property (rd_in && !(addr_in inside {16'hff70, 16'hff71,
      16'hff72, 16'hff74, 16'hff76, 16'hff78, 16'hff79}) |=> rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_status_top: assert property (rd_in && addr_in == 16'hff76 |=> rdata_out[15:12] == 4'h0)
      else $error("status top bits set");
   a_park_level0: assert property (off0_reg == 4'hf |-> modulated_output_pin0_out == !alv0_reg)
      else $error("pin0 not parked");
   a_park_level1: assert property (off1_reg == 4'hf |-> modulated_output_pin1_out == !alv1_reg)
      else $error("pin1 not parked");
   a_quiet_unset0: assert property (s_quiet0 |-> modulated_output_pin0_out == !ctl_reg[0])
      else $error("pin0 pulses without width");
   a_quiet_unset1: assert property (s_quiet1 |-> modulated_output_pin1_out == !ctl_reg[2])
      else $error("pin1 pulses without width");
endmodule // dcp_top_checker

bind dcp_top dcp_top_checker #(.CHANNELS(CHANNELS)) dcp_top_checker_i (
   .clk_sys_in(clk_sys_in),
   .rst_in(rst_in),
   .addr_in(addr_in),
   .wdata_in(wdata_in),
   .wr_in(wr_in),
   .rd_in(rd_in),
   .rdata_out(rdata_out),
   .modulated_output_pin0_out(modulated_output_pin0_out),
   .modulated_output_pin1_out(modulated_output_pin1_out)
);

// >>> verif/tb_dcp_top.sv
// self-checking bench for the two-channel modulator
// assumes dcp_top with its strobe register port and the bound checker
`timescale 1ns/1ps

module tb_dcp_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [15:0] addr = 16'h0000;
   reg [15:0] wdata = 16'h0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   wire [15:0] rdata;
   wire [1:0] pin;
   integer failures = 0;
   integer tests_run = 0;

   dcp_top #(.CHANNELS(2)) dcp_top_i (
      .clk_sys_in(clk),
      .rst_in(rst),
      .addr_in(addr),
      .wdata_in(wdata),
      .wr_in(wr),
      .rd_in(rd),
      .rdata_out(rdata),
      .modulated_output_pin0_out(pin[0]),
      .modulated_output_pin1_out(pin[1])
   );

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // ********
   // bus and compare tasks
   // ********
   task wr_reg(input [15:0] a, input [15:0] d);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   end
   endtask

   task chk(input string what, input [15:0] exp, input [15:0] got);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   end
   endtask

   task rchk(input string what, input [15:0] a, input [15:0] exp);
      reg [15:0] v;
   begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
      chk(what, exp, v);
   end
   endtask

   // count active cycles; a whole frame makes the phase irrelevant
   task mchk(input string what, input integer ch, input lvl, input integer n,
      input [15:0] exp);
      integer k;
      reg [15:0] c;
   begin
      c = 16'h0000;
      for (k = 0; k < n; k = k + 1)
      begin
         @(posedge clk);
         #1;
         if (pin[ch] === lvl)
            c = c + 16'h0001;
      end
      chk(what, exp, c);
   end
   endtask

   task duty0(input [2:0] c, input [15:0] w);
      reg [15:0] d;
      reg [15:0] e;
   begin
      d = (c == 3'h0) ? 16'h0001 : {13'h0000, c};
      e = ({4'h0, w[15:4]} + 16'h0001) * d;
      wr_reg(16'hff70, 16'h0005);
      wr_reg(16'hff71, {13'h0000, c});
      wr_reg(16'hff72, w);
      wr_reg(16'hff70, 16'h0007);
      repeat (20) @(posedge clk);
      mchk("ch0 duty", 0, 1'b1, 4096 * d, e);
   end
   endtask

   task summarize;
   begin
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   initial
   begin
      #2400000;
      failures = failures + 1;
      summarize;
   end

   // ********
   // main sequence
   // ********
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rchk("control", 16'hff70, 16'h0005);
      rchk("divider", 16'hff71, 16'h0000);
      rchk("unmapped", 16'hff7f, 16'h0000);
      $display("test reset done");

      wr_reg(16'hff70, 16'h00ff);
      rchk("control", 16'hff70, 16'h00cf);
      mchk("pin0 unset", 0, 1'b1, 300, 16'h0000);
      mchk("pin1 unset", 1, 1'b1, 300, 16'h0000);
      wr_reg(16'hff79, 16'h000a);
      rchk("control", 16'hff70, 16'h00c5);
      wr_reg(16'hff78, 16'h0030);
      rchk("control", 16'hff70, 16'h00c5);
      wr_reg(16'hff79, 16'h00c0);
      rchk("control", 16'hff70, 16'h0005);
      $display("test control done");

      duty0(3'h3, 16'h12af);
      duty0(3'h4, 16'h8005);
      duty0(3'h2, 16'h0a5f);
      duty0(3'h0, 16'hffff);
      rchk("status", 16'hff76, 16'h0500 | (16'h00ff & 16'h0000));
      $display("test duty done");

      // ch1 active low at /2 while ch0 keeps running
      wr_reg(16'hff71, 16'h0020);
      rchk("divider", 16'hff71, 16'h0020);
      wr_reg(16'hff74, 16'h0a50);
      rchk("width1", 16'hff74, 16'h0a50);
      wr_reg(16'hff70, 16'h000b);
      repeat (20) @(posedge clk);
      mchk("ch1 duty", 1, 1'b0, 8192, 16'd332);
      $display("test channel1 done");

      wr_reg(16'hff79, 16'h0001);
      repeat (6) @(posedge clk);
      mchk("ch0 flip", 0, 1'b0, 4096, 16'd4096);
      wr_reg(16'hff79, 16'h0002);
      repeat (16) @(posedge clk);
      mchk("ch0 off", 0, 1'b1, 50, 16'd50);
      wr_reg(16'hff78, 16'h0001);
      mchk("ch0 held", 0, 1'b1, 50, 16'd50);
      $display("test polarity done");

      wr_reg(16'hff78, 16'h0082);
      repeat (20) @(posedge clk);
      wr_reg(16'hff72, 16'h2000);
      repeat (300) @(posedge clk);
      mchk("ch0 fast", 0, 1'b1, 4096, 16'd513);
      wr_reg(16'hff79, 16'h0080);
      wr_reg(16'hff72, 16'h0100);
      repeat (4120) @(posedge clk);
      mchk("ch0 frame", 0, 1'b1, 4096, 16'd17);
      $display("test update done");
      summarize;
   end
endmodule // tb_dcp_top
